/* design/avr_readback.sv */
// five read-only algorithm variable registers with a dac output selector
`timescale 1ns/10ps
`include "avr_params.svh"

module avr_readback (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic rd_en_i,
    input wire logic wr_en_i,
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    output logic err_o,
    // speed source
    input wire logic speed_src_sel_i,
    input wire logic [14:0] digital_speed_cmd_i,
    input wire logic [31:0] pin_duty_pu_i,
    // algorithm values
    input wire logic [31:0] applied_duty_pu_i,
    input wire logic [31:0] target_duty_pu_i,
    input wire logic [31:0] motor_speed_readback_i,
    input wire logic [31:0] bus_power_pu_i,
    input wire logic update_i,
    // dac output
    input wire logic [2:0] dac_sel_i,
    output logic [11:0] dac_code_o
);
    avr_pkg::avr_word_t cmd_duty_d, cmd_duty_q;
    avr_pkg::avr_word_t app_duty_d, app_duty_q;
    avr_pkg::avr_word_t tgt_duty_d, tgt_duty_q;
    avr_pkg::avr_word_t speed_d, speed_q;
    avr_pkg::avr_word_t power_d, power_q;
    logic [31:0] rdata_d, rdata_q;
    logic rvalid_d, rvalid_q;
    logic err_d, err_q;
    logic [31:0] dig_pu;
    logic [31:0] cmd_src;
    logic [31:0] dac_src;

    // digital command: 7FFF maps just below 2^30; shifting by 15 keeps 32767/32768 of full scale
    assign dig_pu = {2'b00, digital_speed_cmd_i, 15'h0000};
    assign cmd_src = speed_src_sel_i ? dig_pu : pin_duty_pu_i;

    // all five words load together so a read never mixes two update cycles
    always_comb begin
        cmd_duty_d = cmd_duty_q;
        app_duty_d = app_duty_q;
        tgt_duty_d = tgt_duty_q;
        speed_d = speed_q;
        power_d = power_q;
        if (update_i) begin
            cmd_duty_d = cmd_src;
            app_duty_d = applied_duty_pu_i;
            tgt_duty_d = target_duty_pu_i;
            speed_d = motor_speed_readback_i;
            power_d = bus_power_pu_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_duty_q <= `AVR_RST_VALUE;
            app_duty_q <= `AVR_RST_VALUE;
            tgt_duty_q <= `AVR_RST_VALUE;
            speed_q <= `AVR_RST_VALUE;
            power_q <= `AVR_RST_VALUE;
        end else begin
            cmd_duty_q <= cmd_duty_d;
            app_duty_q <= app_duty_d;
            tgt_duty_q <= tgt_duty_d;
            speed_q <= speed_d;
            power_q <= power_d;
        end
    end

    // read decode; writes are accepted and dropped, unmapped reads flag an error
    always_comb begin
        rdata_d = 32'h00000000;
        rvalid_d = 1'b0;
        err_d = 1'b0;
        if (rd_en_i) begin
            rvalid_d = 1'b1;
            case (addr_i)
                `AVR_OFS_CMD_DUTY: rdata_d = cmd_duty_q;
                `AVR_OFS_APP_DUTY: rdata_d = app_duty_q;
                `AVR_OFS_TGT_DUTY: rdata_d = tgt_duty_q;
                `AVR_OFS_SPEED: rdata_d = speed_q;
                `AVR_OFS_POWER: rdata_d = power_q;
                default: err_d = 1'b1;
            endcase
        end else if (wr_en_i) begin
            err_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            err_q <= err_d;
        end
    end

    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign err_o = err_q;

    always_comb begin
        case (dac_sel_i)
            avr_pkg::AVR_SEL_CMD_DUTY: dac_src = cmd_duty_q;
            avr_pkg::AVR_SEL_APP_DUTY: dac_src = app_duty_q;
            avr_pkg::AVR_SEL_TGT_DUTY: dac_src = tgt_duty_q;
            avr_pkg::AVR_SEL_SPEED: dac_src = speed_q;
            avr_pkg::AVR_SEL_POWER: dac_src = power_q;
            default: dac_src = 32'h00000000;
        endcase
    end

    avr_dac_scale i_avr_dac_scale (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pu_i(dac_src),
        .code_o(dac_code_o)
    );

    // a read takes two steps: the request edge here, the answer on the next edge
    sequence s_ask_cmd_duty;
        rd_en_i && (addr_i == `AVR_OFS_CMD_DUTY);
    endsequence
    sequence s_ask_app_duty;
        rd_en_i && (addr_i == `AVR_OFS_APP_DUTY);
    endsequence
    sequence s_ask_tgt_duty;
        rd_en_i && (addr_i == `AVR_OFS_TGT_DUTY);
    endsequence
    sequence s_ask_speed;
        rd_en_i && (addr_i == `AVR_OFS_SPEED);
    endsequence
    sequence s_ask_power;
        rd_en_i && (addr_i == `AVR_OFS_POWER);
    endsequence
    sequence s_ask_unmapped;
        rd_en_i && (addr_i != `AVR_OFS_CMD_DUTY) && (addr_i != `AVR_OFS_APP_DUTY) &&
            (addr_i != `AVR_OFS_TGT_DUTY) && (addr_i != `AVR_OFS_SPEED) &&
            (addr_i != `AVR_OFS_POWER);
    endsequence

    a_cmd_pin_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (update_i && !speed_src_sel_i) |=> (cmd_duty_q == $past(pin_duty_pu_i)))
        else $error("commanded duty not from speed pin");
    a_cmd_dig_src: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (update_i && speed_src_sel_i) |=> (cmd_duty_q[29:15] == $past(digital_speed_cmd_i)))
        else $error("commanded duty not from digital command");
    a_app_duty_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        update_i |=> (app_duty_q == $past(applied_duty_pu_i)))
        else $error("applied duty not captured");
    a_tgt_duty_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        update_i |=> (tgt_duty_q == $past(target_duty_pu_i)))
        else $error("target duty not captured");
    a_speed_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        update_i |=> (speed_q == $past(motor_speed_readback_i)))
        else $error("motor speed not captured");
    a_power_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        update_i |=> (power_q == $past(bus_power_pu_i)))
        else $error("bus power not captured");
    a_write_no_effect: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en_i && !update_i) |=> $stable(speed_q) && $stable(cmd_duty_q))
        else $error("write changed a read-only register");
    // write data that differs from speed_q must never land in speed_q
    a_write_data_dropped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en_i && !update_i && (wdata_i != speed_q)) |=> (speed_q != $past(wdata_i)))
        else $error("write data landed in a read-only register");
    a_hold_snapshot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !update_i |=> ($stable(cmd_duty_q) && $stable(app_duty_q) && $stable(tgt_duty_q) &&
            $stable(speed_q) && $stable(power_q)))
        else $error("snapshot moved without a capture strobe");
    a_read_cmd_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_ask_cmd_duty |=> (rvalid_o && !err_o && (rdata_o == $past(cmd_duty_q))))
        else $error("commanded duty read not coherent");
    a_read_app_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_ask_app_duty |=> (rvalid_o && !err_o && (rdata_o == $past(app_duty_q))))
        else $error("applied duty read not coherent");
    a_read_tgt_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_ask_tgt_duty |=> (rvalid_o && !err_o && (rdata_o == $past(tgt_duty_q))))
        else $error("target duty read not coherent");
    a_read_speed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_ask_speed |=> rvalid_o && rdata_o == $past(speed_q))
        else $error("speed read not coherent");
    a_read_power: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_ask_power |=> (rvalid_o && !err_o && (rdata_o == $past(power_q))))
        else $error("bus power read not coherent");
    a_read_unmapped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_ask_unmapped |=> (rvalid_o && err_o && (rdata_o == 32'h00000000)))
        else $error("unmapped read not flagged");
    // the read port stays quiet between reads so a host never latches stale data
    a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rd_en_i |=> (!rvalid_o && !err_o && (rdata_o == 32'h00000000)))
        else $error("read port active without a read");
    a_dac_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ((dac_sel_i == avr_pkg::AVR_SEL_SPEED) && !speed_q[31] && !speed_q[30]) |=>
            (dac_code_o == $past(speed_q[29:18])))
        else $error("speed not routed to the dac");
    a_dac_unused_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (dac_sel_i > 3'h4) |=> (dac_code_o == 12'h000))
        else $error("unused dac select gives a nonzero code");
    a_reset_zero: assert property (@(posedge clk_i)
        !rst_n_i |=> (power_q == `AVR_RST_VALUE && cmd_duty_q == `AVR_RST_VALUE))
        else $error("register not zero after reset");
    a_reset_rest: assert property (@(posedge clk_i)
        !rst_n_i |=> ((app_duty_q == `AVR_RST_VALUE) && (tgt_duty_q == `AVR_RST_VALUE) &&
            (speed_q == `AVR_RST_VALUE)))
        else $error("variable not zero after reset");
    a_reset_port: assert property (@(posedge clk_i)
        !rst_n_i |=> ((rdata_o == 32'h00000000) && !rvalid_o && !err_o))
        else $error("read port not idle after reset");
endmodule : avr_readback

/* design/avr_params.svh */
// register offsets, reset values and scaling constants of the algorithm variable readback bank
`ifndef AVR_PARAMS_SVH
`define AVR_PARAMS_SVH
`define AVR_OFS_CMD_DUTY 12'h40C
`define AVR_OFS_APP_DUTY 12'h4F6
`define AVR_OFS_TGT_DUTY 12'h506
`define AVR_OFS_SPEED 12'h5B2
`define AVR_OFS_POWER 12'h6F4
`define AVR_RST_VALUE 32'h00000000
`define AVR_PU_SHIFT 30
`define AVR_PU_FULL 32'h40000000
`define AVR_DIG_CMD_FULL 15'h7FFF
`define AVR_SPEED_DIV 16
`define AVR_POWER_DIV 4
`define AVR_DAC_FULL_MV 3000
`define AVR_DAC_BITS 12
`define AVR_DAC_MAX 12'hFFF
`define AVR_DAC_MV_PER_LSB_NUM 3000
`endif

/* design/avr_pkg.sv */
// types of the algorithm variable readback bank
package avr_pkg;
    typedef enum logic [2:0] {
        AVR_SEL_CMD_DUTY,
        AVR_SEL_APP_DUTY,
        AVR_SEL_TGT_DUTY,
        AVR_SEL_SPEED,
        AVR_SEL_POWER
    } avr_dac_sel_t;
    typedef logic [31:0] avr_word_t;
endpackage : avr_pkg

/* design/avr_dac_scale.sv */
// scales one per-unit variable to a dac code where full code stands for 3 v
`timescale 1ns/10ps
`include "avr_params.svh"
module avr_dac_scale (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // per-unit value in
    input wire logic [31:0] pu_i,
    // dac code out
    output logic [11:0] code_o
);
    logic [11:0] code_d;
    logic [11:0] code_q;

    // linear map: 2^30 gives full code; negative reads as zero, above full saturates
    always_comb begin
        if (pu_i[31]) begin
            code_d = 12'h000;
        end else if (pu_i[30]) begin
            code_d = `AVR_DAC_MAX;
        end else begin
            code_d = pu_i[29:18];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            code_q <= 12'h000;
        end else begin
            code_q <= code_d;
        end
    end

    assign code_o = code_q;

    a_dac_linear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!pu_i[31] && !pu_i[30]) |=> (code_o == $past(pu_i[29:18])))
        else $error("dac code not linear in value");
    a_dac_full: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (pu_i == `AVR_PU_FULL) |=> (code_o == `AVR_DAC_MAX))
        else $error("full scale value does not give full dac code");
    a_dac_negative: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pu_i[31] |=> (code_o == 12'h000))
        else $error("negative value does not give zero dac code");
endmodule : avr_dac_scale

/* sim/avr_readback_tb.sv */
// self-checking testbench of the algorithm variable readback bank
`timescale 1ns/10ps
`include "avr_params.svh"
module avr_readback_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic wr_en_i = 1'b0;
    logic [11:0] addr_i = 12'h000;
    logic [31:0] wdata_i = 32'h00000000;
    logic speed_src_sel_i = 1'b0;
    logic [14:0] digital_speed_cmd_i = 15'h0000;
    logic update_i = 1'b0;
    logic [2:0] dac_sel_i = 3'h0;
    logic [31:0] rdata_o;
    logic rvalid_o;
    logic err_o;
    logic [11:0] dac_code_o;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [11:0] ofs [5] = '{`AVR_OFS_CMD_DUTY, `AVR_OFS_APP_DUTY, `AVR_OFS_TGT_DUTY,
                             `AVR_OFS_SPEED, `AVR_OFS_POWER};
    // half, full, small, mid and negative values exercise every dac mapping branch
    logic [31:0] val [5] = '{32'h20000000, 32'h40000000, 32'h01234567, 32'h15540000,
                             32'h80000000};
    logic [31:0] vin [5] = '{32'h20000000, 32'h40000000, 32'h01234567, 32'h15540000,
                             32'h80000000};

    avr_readback i_avr_readback (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .err_o(err_o), .speed_src_sel_i(speed_src_sel_i),
        .digital_speed_cmd_i(digital_speed_cmd_i), .pin_duty_pu_i(vin[0]),
        .applied_duty_pu_i(vin[1]), .target_duty_pu_i(vin[2]), .motor_speed_readback_i(vin[3]),
        .bus_power_pu_i(vin[4]), .update_i(update_i), .dac_sel_i(dac_sel_i),
        .dac_code_o(dac_code_o)
    );

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e);
        @(posedge clk_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1;
        chk({30'h0, rvalid_o, err_o}, {30'h0, 1'b1, e});
        chk(rdata_o, exp);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask : wr

    task automatic pulse_update();
        @(posedge clk_i);
        update_i <= 1'b1;
        @(posedge clk_i);
        update_i <= 1'b0;
    endtask : pulse_update

    function automatic logic [31:0] dac_exp(input logic [31:0] v);
        if (v[31]) return 32'h00000000;
        if (v >= `AVR_PU_FULL) return {20'h0, `AVR_DAC_MAX};
        return {20'h0, v[29:18]};
    endfunction : dac_exp

    task automatic tally_and_finish();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // the whole sequence needs about 85 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) rd(ofs[i], `AVR_RST_VALUE, 1'b0);
        pulse_update();
        for (int i = 0; i < 5; i++) wr(ofs[i], 32'hFFFFFFFF);
        @(posedge clk_i);
        // inputs move without a capture strobe: the snapshot must not follow them
        for (int i = 0; i < 5; i++) vin[i] <= ~val[i];
        for (int i = 0; i < 5; i++) rd(ofs[i], val[i], 1'b0);
        rd(12'h40D, 32'h00000000, 1'b1);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i);
            dac_sel_i <= 3'(i);
            repeat (3) @(posedge clk_i);
            #1;
            chk({20'h0, dac_code_o}, (i < 5) ? dac_exp(val[i]) : 32'h0);
        end
        @(posedge clk_i);
        speed_src_sel_i <= 1'b1;
        digital_speed_cmd_i <= `AVR_DIG_CMD_FULL;
        pulse_update();
        rd(`AVR_OFS_CMD_DUTY, {2'b00, `AVR_DIG_CMD_FULL, 15'h0000}, 1'b0);
        @(posedge clk_i);
        speed_src_sel_i <= 1'b0;
        pulse_update();
        rd(`AVR_OFS_CMD_DUTY, ~val[0], 1'b0);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(`AVR_OFS_POWER, `AVR_RST_VALUE, 1'b0);
        tally_and_finish();
    end
endmodule : avr_readback_tb
